// ==== hdl/counter_latch_readback.sv ====
module counter_latch_readback
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic ext_clock0,
  input wire logic gate0,
  input wire logic clock0_internal,
  input wire logic chain_gate,
  output logic [2:0] timer_out
);

  // Per-counter host-side state
  typedef struct packed {
    logic [1:0] access;      // Programmed byte access
    logic [2:0] mode;        // Programmed mode bits
    logic bcd;               // Decimal counting
    logic wr_ptr;            // Next write is high byte
    logic [7:0] wr_low;      // Low byte awaiting its pair
    logic rd_ptr;            // Next direct read is high byte
    logic [15:0] hold;       // Hold register
    logic latched;           // Hold register not yet read
    logic lat_ptr;           // Next held byte is high
    logic [7:0] status;      // Captured status byte
    logic status_held;       // Status waiting to be read
    logic null_flag;         // New count not transferred
    logic load;              // Load pulse to the core
    logic [15:0] load_val;   // Value for the core
    logic ctrl_wr;           // Mode written pulse
  } chan_t;

  // Whole block state
  typedef struct packed {
    chan_t [2:0] ch;
    logic [7:0] rdata;       // Read answer
    logic rvalid;            // Read answer strobe
    logic [2:0] clk_sync;    // External clock synchroniser
    logic clk_level;         // Accepted clock level
    logic [2:0] gate_sync;   // Gate synchroniser
    logic gate_level;        // Accepted gate level
    logic [4:0] prescale;    // Internal source divider
    logic int_tick;          // Internal source pulse
    logic [2:0] tick;        // Count pulse per counter
    logic out1_d;            // Previous counter 1 output
  } top_t;

  top_t s;
  top_t n;

  // Core outputs and core gate inputs
  logic [15:0] core_count [3];
  logic [2:0] core_level;
  logic [2:0] core_loaded;
  logic [2:0] core_gate;

  // Decode helpers
  logic [1:0] sel;
  logic [1:0] acc;
  logic [1:0] idx;
  logic data_hit;
  logic ext_rise;

  assign sel = io_wdata[POS_COUNTER_SEL_LO +: 2];
  assign acc = io_wdata[POS_ACCESS_MODE_LO +: 2];
  assign data_hit = (io_addr >= OFF_DATA0) && (io_addr <= OFF_DATA2);
  assign idx = 2'(io_addr - OFF_DATA0);
  // Clock edge once second and third stages agree
  assign ext_rise = (s.clk_sync[1] == s.clk_sync[2]) && s.clk_sync[2] && !s.clk_level;

  // Counter 0 gated by pin, the chain by program control
  assign core_gate = {chain_gate, chain_gate, s.gate_level};

  // Status byte of one counter
  function automatic logic [7:0] status_of(input chan_t c, input logic lvl);
    return {lvl, c.null_flag, c.access, c.mode, c.bcd};
  endfunction

  // Byte of a word chosen by access mode and pointer
  function automatic logic [7:0] pick(input logic [15:0] w, input logic [1:0] a,
                                      input logic hi);
    if (a == ACC_HIGH || (a == ACC_WORD && hi))
      return w[15:8];
    return w[7:0];
  endfunction

  // Next state of the whole block
  always_comb
  begin
    n = s;
    n.rvalid = 1'b0;
    // Pin synchronisers
    n.clk_sync = {s.clk_sync[1:0], ext_clock0};
    n.gate_sync = {s.gate_sync[1:0], gate0};
    if (s.clk_sync[1] == s.clk_sync[2])
      n.clk_level = s.clk_sync[2];
    if (s.gate_sync[1] == s.gate_sync[2])
      n.gate_level = s.gate_sync[2];
    // Internal 1MHz source
    n.prescale = (s.prescale == PRESCALE_LAST) ? 5'h00 : s.prescale + 5'h01;
    n.int_tick = (s.prescale == PRESCALE_LAST);
    // Count pulses, counter 2 clocked by counter 1 output
    n.out1_d = core_level[1];
    n.tick[0] = clock0_internal ? s.int_tick : ext_rise;
    n.tick[1] = s.int_tick;
    n.tick[2] = core_level[1] && !s.out1_d;

    for (int i = 0; i < 3; i++)
    begin
      n.ch[i].load = 1'b0;
      n.ch[i].ctrl_wr = 1'b0;
      // Transfer into the core ends the null count
      if (core_loaded[i])
        n.ch[i].null_flag = 1'b0;
    end

    // Control location writes
    if (io_wr && io_addr == OFF_CONTROL)
    begin
      if (sel == SEL_READBACK)
      begin
        // Readback, ignored if bit 0 is set
        if (!io_wdata[POS_BCD])
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (io_wdata[POS_MASK_COUNTER_ZERO + i])
            begin
              // All masked counts not already held latched in this one cycle
              if (!io_wdata[POS_COUNT_LATCH_N] && !s.ch[i].latched)
              begin
                n.ch[i].hold = core_count[i];
                n.ch[i].latched = 1'b1;
                n.ch[i].lat_ptr = 1'b0;
              end
              if (!io_wdata[POS_STATUS_LATCH_N] && !s.ch[i].status_held)
              begin
                n.ch[i].status = status_of(s.ch[i], core_level[i]);
                n.ch[i].status_held = 1'b1;
              end
              // Both selectors high leave the latches alone
            end
          end
        end
      end
      else if (acc == ACC_LATCH)
      begin
        // Single counter latch, once until read
        if (!s.ch[sel].latched)
        begin
          n.ch[sel].hold = core_count[sel];
          n.ch[sel].latched = 1'b1;
          n.ch[sel].lat_ptr = 1'b0;
        end
      end
      else
      begin
        // New access and counting mode
        n.ch[sel].access = acc;
        n.ch[sel].mode = io_wdata[POS_MODE_BIT_ZERO +: 3];
        n.ch[sel].bcd = io_wdata[POS_BCD];
        n.ch[sel].wr_ptr = 1'b0;
        n.ch[sel].rd_ptr = 1'b0;
        n.ch[sel].null_flag = 1'b1;
        n.ch[sel].ctrl_wr = 1'b1;
      end
    end

    // Data location writes
    if (io_wr && data_hit)
    begin
      unique case (s.ch[idx].access)
        ACC_LOW:
        begin
          n.ch[idx].load_val = {8'h00, io_wdata};
          n.ch[idx].load = 1'b1;
          n.ch[idx].null_flag = 1'b1;
        end
        ACC_HIGH:
        begin
          n.ch[idx].load_val = {io_wdata, 8'h00};
          n.ch[idx].load = 1'b1;
          n.ch[idx].null_flag = 1'b1;
        end
        ACC_WORD:
        begin
          // Low byte first, high byte completes the load
          n.ch[idx].wr_ptr = !s.ch[idx].wr_ptr;
          if (!s.ch[idx].wr_ptr)
            n.ch[idx].wr_low = io_wdata;
          else
          begin
            n.ch[idx].load_val = {io_wdata, s.ch[idx].wr_low};
            n.ch[idx].load = 1'b1;
            n.ch[idx].null_flag = 1'b1;
          end
        end
        default:
          n.ch[idx].wr_ptr = s.ch[idx].wr_ptr;
      endcase
    end

    // Reads
    if (io_rd)
    begin
      n.rvalid = 1'b1;
      n.rdata = CONTROL_READ_VALUE;
      if (data_hit)
      begin
        if (s.ch[idx].status_held)
        begin
          // Status always goes out before a held count
          n.rdata = s.ch[idx].status;
          n.ch[idx].status_held = 1'b0;
        end
        else if (s.ch[idx].latched)
        begin
          // Held value while the core keeps counting
          n.rdata = pick(s.ch[idx].hold, s.ch[idx].access, s.ch[idx].lat_ptr);
          if (s.ch[idx].access == ACC_WORD && !s.ch[idx].lat_ptr)
            n.ch[idx].lat_ptr = 1'b1;
          else
            n.ch[idx].latched = 1'b0;
        end
        else
        begin
          // Direct read, trusted only with counting stopped
          n.rdata = pick(core_count[idx], s.ch[idx].access, s.ch[idx].rd_ptr);
          if (s.ch[idx].access == ACC_WORD)
            n.ch[idx].rd_ptr = !s.ch[idx].rd_ptr;
        end
      end
    end
  end

  // State register, reset clears all latches and pointers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      for (int i = 0; i < 3; i++)
      begin
        s.ch[i].access <= RST_ACCESS;
        s.ch[i].mode <= RST_MODE;
        s.ch[i].hold <= RST_COUNT;
      end
    end
    else
      s <= n;
  end

  // One counting element per counter
  for (genvar g = 0; g < 3; g++)
  begin : g_core
    down_counter_core u_core (
      .mclk(mclk),
      .arst_n(arst_n),
      .tick(s.tick[g]),
      .gate(core_gate[g]),
      .ctrl_wr(s.ch[g].ctrl_wr),
      .load(s.ch[g].load),
      .load_val(s.ch[g].load_val),
      .mode(mode_fold(s.ch[g].mode)),
      .bcd(s.ch[g].bcd),
      .count(core_count[g]),
      .level(core_level[g]),
      .loaded(core_loaded[g])
    );
  end

  // Outputs straight from flops
  assign io_rdata = s.rdata;
  assign io_rvalid = s.rvalid;
  assign timer_out = core_level;

endmodule

// ==== hdl/timer_pkg.sv ====
package timer_pkg;

  // Main clock and internal counting source
  localparam int unsigned MCLK_HZ = 25_000_000;
  localparam int unsigned INT_CLK_HZ = 1_000_000;
  // Main clocks per internal source period
  localparam int unsigned PRESCALE = MCLK_HZ / INT_CLK_HZ;
  localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE - 1);

  // Byte-wide I/O offsets
  localparam logic [3:0] OFF_DATA0 = 4'h8;
  localparam logic [3:0] OFF_DATA2 = 4'hA;
  localparam logic [3:0] OFF_CONTROL = 4'hB;

  // Control byte field positions
  localparam int POS_COUNTER_SEL_LO = 6;
  localparam int POS_ACCESS_MODE_LO = 4;
  localparam int POS_MODE_BIT_ZERO = 1;
  localparam int POS_BCD = 0;

  // Readback command field positions
  localparam int POS_COUNT_LATCH_N = 5;
  localparam int POS_STATUS_LATCH_N = 4;
  localparam int POS_MASK_COUNTER_ZERO = 1;

  // Counter selector and access mode codes
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LOW = 2'h1;
  localparam logic [1:0] ACC_HIGH = 2'h2;
  localparam logic [1:0] ACC_WORD = 2'h3;

  // Counting modes after folding the don't-care bit
  localparam logic [2:0] MODE_TERMINAL = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;

  // Reset values and the control location read value
  localparam logic [1:0] RST_ACCESS = ACC_LOW;
  localparam logic [2:0] RST_MODE = MODE_TERMINAL;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] CONTROL_READ_VALUE = 8'h00;

  // Modes 2 and 3 ignore the top mode bit
  function automatic logic [2:0] mode_fold(input logic [2:0] m);
    return m[1] ? {1'b0, m[1:0]} : m;
  endfunction

endpackage

// ==== hdl/down_counter_core.sv ====
module down_counter_core
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic gate,
  input wire logic ctrl_wr,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [2:0] mode,
  input wire logic bcd,
  output logic [15:0] count,
  output logic level,
  output logic loaded
);

  // Whole counting element state
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] init;
    logic pending;
    logic trig;
    logic gate_d;
    logic running;
    logic armed;
    logic extra;
    logic level;
    logic loaded;
  } core_t;

  core_t s;
  core_t n;
  logic [15:0] dec;
  logic trig_mode;
  logic sq;

  // One step down, binary or decimal
  function automatic logic [15:0] step(input logic [15:0] v, input logic dm);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!dm)
      r = v - 16'h0001;
    else
      for (int d = 0; d < 4; d++)
      begin
        if (borrow)
        begin
          borrow = (v[d*4 +: 4] == 4'h0);
          r[d*4 +: 4] = borrow ? 4'h9 : v[d*4 +: 4] - 4'h1;
        end
      end
    return r;
  endfunction

  assign dec = step(s.count, bcd);
  assign trig_mode = (mode != MODE_TERMINAL) && (mode != MODE_SW_STROBE);
  assign sq = (mode == MODE_SQUARE);

  // Next state of the counting element
  always_comb
  begin
    n = s;
    n.loaded = 1'b0;
    n.gate_d = gate;
    // Rising gate is a trigger
    if (gate && !s.gate_d)
      n.trig = 1'b1;
    // New mode resets the sequence
    if (ctrl_wr)
    begin
      n.pending = 1'b0;
      n.trig = 1'b0;
      n.running = 1'b0;
      n.armed = 1'b0;
      n.extra = 1'b0;
      n.level = (mode != MODE_TERMINAL);
    end
    else if (load)
    begin
      n.init = load_val;
      if (mode == MODE_TERMINAL)
        n.level = 1'b0;
      // Periodic modes take a new value at the next reload
      n.pending = !(mode == MODE_ONESHOT || mode == MODE_HW_STROBE) &&
                  (!trig_mode || !s.running);
    end
    // Low gate parks periodic outputs high
    if (!gate && (mode == MODE_RATE || sq))
      n.level = 1'b1;
    if (tick && !ctrl_wr)
    begin
      if (s.pending || (s.trig && trig_mode))
      begin
        // Transfer into the counting element
        n.count = sq ? {s.init[15:1], 1'b0} : s.init;
        n.pending = 1'b0;
        n.trig = 1'b0;
        n.loaded = s.pending;
        n.running = 1'b1;
        n.armed = 1'b1;
        n.extra = sq && s.init[0];
        if (mode == MODE_ONESHOT)
          n.level = 1'b0;
        else if (mode != MODE_TERMINAL)
          n.level = 1'b1;
      end
      else if (s.running && (gate || mode == MODE_ONESHOT || mode == MODE_HW_STROBE))
      begin
        unique case (mode)
          MODE_TERMINAL:
          begin
            n.count = dec;
            if (dec == 16'h0000)
              n.level = 1'b1;
          end
          MODE_ONESHOT:
          begin
            n.count = dec;
            if (s.count == 16'h0001)
              n.level = 1'b1;
          end
          MODE_RATE:
          begin
            // Low for one input period, then reload
            n.count = (s.count == 16'h0001) ? s.init : dec;
            n.level = (s.count == 16'h0001) || (dec != 16'h0001);
          end
          MODE_SQUARE:
          begin
            if (s.count <= 16'h0002)
            begin
              // Odd divisor stretches the high half by one period
              if (s.extra)
                n.extra = 1'b0;
              else
              begin
                n.level = !s.level;
                n.count = {s.init[15:1], 1'b0};
                n.extra = !s.level && s.init[0];
              end
            end
            else
              n.count = step(dec, bcd);
          end
          MODE_SW_STROBE, MODE_HW_STROBE:
          begin
            // One low period at terminal count
            n.count = dec;
            n.level = !(s.count == 16'h0001 && s.armed);
            if (s.count == 16'h0001)
              n.armed = 1'b0;
          end
          default:
            n.count = dec;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= n;
  end

  assign count = s.count;
  assign level = s.level;
  assign loaded = s.loaded;

endmodule

// ==== test/counter_latch_readback_chk.sv ====
module counter_latch_readback_chk
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic ext_clock0,
  input wire logic gate0,
  input wire logic clock0_internal,
  input wire logic chain_gate,
  input wire logic [2:0] timer_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Single clock domain for every property
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Read of the control location
  sequence s_ctrl_read;
    io_rd && io_addr == OFF_CONTROL;
  endsequence
  // Read of a location outside the map
  sequence s_hole_read;
    io_rd && (io_addr < OFF_DATA0 || io_addr > OFF_CONTROL);
  endsequence
  // Two reads on consecutive edges
  sequence s_two_reads;
    io_rd ##1 io_rd;
  endsequence

  property p_read_answer;
    io_rd |=> io_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_answer_needs_read;
    !io_rd |=> !io_rvalid;
  endproperty
  a_answer_needs_read: assert property (p_answer_needs_read) else $error("stray answer");
  property p_write_no_answer;
    io_wr && !io_rd |=> !io_rvalid;
  endproperty
  a_write_no_answer: assert property (p_write_no_answer) else $error("write answered");
  property p_ctrl_reads_fixed;
    s_ctrl_read |=> io_rdata == CONTROL_READ_VALUE;
  endproperty
  a_ctrl_reads_fixed: assert property (p_ctrl_reads_fixed) else $error("control read");
  property p_hole_reads_zero;
    s_hole_read |=> io_rvalid && io_rdata == 8'h00;
  endproperty
  a_hole_reads_zero: assert property (p_hole_reads_zero) else $error("unmapped read");
  property p_rdata_holds;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  property p_two_answers;
    s_two_reads |=> io_rvalid && $past(io_rvalid);
  endproperty
  a_two_answers: assert property (p_two_answers) else $error("back to back read lost");
  property p_answer_then_quiet;
    io_rd ##1 !io_rd |=> !io_rvalid [*1];
  endproperty
  a_answer_then_quiet: assert property (p_answer_then_quiet) else $error("answer too long");
endmodule

bind counter_latch_readback counter_latch_readback_chk chk (.mclk(mclk), .arst_n(arst_n),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .ext_clock0(ext_clock0), .gate0(gate0),
  .clock0_internal(clock0_internal), .chain_gate(chain_gate), .timer_out(timer_out));

// ==== test/counter_latch_readback_tb.sv ====
module counter_latch_readback_tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] io_addr = 4'h0;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_rdata;
  logic io_rvalid;
  logic ext_clock0 = 1'b0; // Counter 0 pulses from the bench
  logic gate0 = 1'b0;
  logic chain_gate = 1'b0;
  logic [2:0] timer_out;
  int mismatches = 0;
  int checks_done = 0;
  int hi_len;
  int lo_len;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  counter_latch_readback DUT (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .ext_clock0(ext_clock0), .gate0(gate0),
    .clock0_internal(1'b0), .chain_gate(chain_gate), .timer_out(timer_out));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask

  // One-cycle read strobe, answer one cycle later
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    chk(16'(io_rvalid), 16'h0001);
    chk(16'(io_rdata), 16'(exp));
  endtask

  // Low then high byte read, strobe held for two back to back accesses
  task automatic rdw(input logic [3:0] a, input logic [15:0] exp);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    chk(16'(io_rvalid), 16'h0001);
    chk(16'(io_rdata), 16'(exp[7:0]));
    @(negedge mclk);
    io_rd = 1'b0;
    chk(16'(io_rvalid), 16'h0001);
    chk(16'(io_rdata), 16'(exp[15:8]));
  endtask

  // Counter 0 pulses, slow enough for the pin synchroniser
  task automatic pulse(input int k);
    repeat (k)
    begin
      ext_clock0 = 1'b1;
      cyc(5);
      ext_clock0 = 1'b0;
      cyc(5);
    end
  endtask

  // Bounded wait for a counter 1 output level
  task automatic wait_out1(input logic v, output int n);
    n = 0;
    while (timer_out[1] !== v && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 1000)
    begin
      mismatches++;
      print_verdict();
    end
  endtask

  // Main sequence
  initial
  begin
    cyc(16);
    arst_n = 1'b1;
    rd(OFF_CONTROL, CONTROL_READ_VALUE);
    rd(4'h3, 8'h00);
    $display("test reset reads done");
    wr(OFF_CONTROL, 8'h30);
    wr(OFF_DATA0, 8'hFF);
    wr(OFF_DATA0, 8'hFF);
    wr(OFF_CONTROL, 8'hE2);
    rd(OFF_DATA0, 8'h70);
    pulse(1);
    wr(OFF_CONTROL, 8'hE2);
    rd(OFF_DATA0, 8'h30);
    rdw(OFF_DATA0, 16'hFFFF);
    gate0 = 1'b1;
    cyc(6);
    pulse(5);
    gate0 = 1'b0;
    cyc(6);
    wr(OFF_CONTROL, 8'h00);
    pulse(3);
    gate0 = 1'b1;
    cyc(6);
    pulse(2);
    wr(OFF_CONTROL, 8'h00);
    rdw(OFF_DATA0, 16'hFFFA);
    gate0 = 1'b0;
    cyc(6);
    wr(OFF_CONTROL, 8'h00);
    rdw(OFF_DATA0, 16'hFFF8);
    $display("test latch and gate done");
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_CONTROL, 8'hE2);
    rd(OFF_DATA0, 8'h30);
    rdw(OFF_DATA0, 16'hFFF8);
    wr(OFF_CONTROL, 8'hC2);
    rd(OFF_DATA0, 8'h30);
    rdw(OFF_DATA0, 16'hFFF8);
    wr(OFF_CONTROL, 8'hF2);
    rdw(OFF_DATA0, 16'hFFF8);
    wr(OFF_CONTROL, 8'hC3);
    rdw(OFF_DATA0, 16'hFFF8);
    $display("test readback done");
    wr(OFF_CONTROL, 8'h70);
    wr(4'h9, 8'h34);
    wr(4'h9, 8'h12);
    wr(OFF_CONTROL, 8'hB0);
    wr(OFF_DATA2, 8'h78);
    wr(OFF_DATA2, 8'h56);
    cyc(60);
    wr(OFF_CONTROL, 8'hDE);
    rdw(OFF_DATA0, 16'hFFF8);
    rdw(4'h9, 16'h1234);
    rdw(OFF_DATA2, 16'h0000);
    wr(OFF_CONTROL, 8'hE8);
    rd(OFF_DATA2, 8'h70);
    rdw(4'h9, 16'h1234);
    $display("test counter mask done");
    wr(OFF_CONTROL, 8'h50);
    wr(4'h9, 8'h77);
    cyc(60);
    rd(4'h9, 8'h77);
    rd(4'h9, 8'h77);
    wr(OFF_CONTROL, 8'h60);
    wr(4'h9, 8'h12);
    cyc(60);
    rd(4'h9, 8'h12);
    $display("test byte modes done");
    wr(OFF_CONTROL, 8'h56);
    wr(4'h9, 8'h05);
    chain_gate = 1'b1;
    wait_out1(1'b0, hi_len);
    wait_out1(1'b1, hi_len);
    wait_out1(1'b0, hi_len);
    wait_out1(1'b1, lo_len);
    chk(16'(hi_len - lo_len), 16'(PRESCALE));
    chk(16'(hi_len + lo_len), 16'(5 * PRESCALE));
    // Counter 2 took its count on the mode write rise, then saw two more rises
    cyc(2);
    chk(16'(timer_out), 16'h0002);
    wr(OFF_CONTROL, 8'h80);
    rdw(OFF_DATA2, 16'h5676);
    $display("test odd square wave done");
    print_verdict();
  end
endmodule
